// ===== rtl/serial_frame_pkg.sv
/*
  Shared constants for the serial command frame master: function codes,
  frame characters, check seeds, status codes, timing and the sequencer states.
  Assumes a single 40 MHz system clock.
*/
package serial_frame_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ           = 40_000_000;
  localparam int SILENT_MS        = 10;
  localparam int SILENT_CYC       = SILENT_MS * (CLK_HZ / 1000);
  localparam int RESP_TIMEOUT_MS  = 100;
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int CNT_W            = 23;

  // ----------------------------------------------------------------------
  // Frame contents
  // ----------------------------------------------------------------------
  localparam logic [7:0]  FUNC_WR_SINGLE = 8'h06;
  localparam logic [7:0]  FUNC_WR_MULTI  = 8'h10;
  localparam logic [3:0]  MAX_WORDS      = 4'ha;
  localparam logic [7:0]  CHAR_START     = 8'h3a;
  localparam logic [7:0]  CHAR_CR        = 8'h0d;
  localparam logic [7:0]  CHAR_LF        = 8'h0a;
  localparam logic [7:0]  LRC_INIT       = 8'h00;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'ha001;
  localparam logic [3:0]  REPLY_LEN_ASC  = 4'h7;
  localparam logic [3:0]  REPLY_LEN_RTU  = 4'h8;
  localparam logic [3:0]  REPLY_ECHO_LEN = 4'h6;

  // ----------------------------------------------------------------------
  // Result codes and buffering
  // ----------------------------------------------------------------------
  localparam logic [2:0] ST_OK       = 3'h0;
  localparam logic [2:0] ST_CHECK    = 3'h1;
  localparam logic [2:0] ST_MISMATCH = 3'h2;
  localparam logic [2:0] ST_TIMEOUT  = 3'h3;
  localparam logic [2:0] ST_REFUSED  = 3'h4;
  localparam int         WORD_W      = 16;
  localparam int         FIFO_WORDS  = 32;

  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_LEAD  = 6'h02,
    S_BODY  = 6'h04,
    S_CHECK = 6'h08,
    S_TAIL  = 6'h10,
    S_WAIT  = 6'h20
  } seq_state_t;

endpackage

// ===== rtl/word_fifo.sv
/*
  Synchronous word FIFO with a registered output stage.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,   // System clock
  input  wire logic             rst,       // Synchronous reset
  input  wire logic             in_valid,  // Write word offered
  output logic                  in_ready,  // Room in storage
  input  wire logic [WIDTH-1:0] in_data,   // Write word
  output logic                  out_valid, // Head word present
  input  wire logic             out_ready, // Head word taken
  output logic      [WIDTH-1:0] out_data   // Head word, registered
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      used;
  logic             push;
  logic             load;

  assign in_ready = (used != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign load     = (used != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      used   <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (load) rd_ptr <= rd_ptr + 1'b1;
      case ({push, load})
        2'b10:   used <= used + 1'b1;
        2'b01:   used <= used - 1'b1;
        default: used <= used;
      endcase
    end
  end

  // Output stage lets the consumer see data from a flip-flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule // word_fifo

// ===== rtl/frame_master.sv
/*
  Master side of the serial command protocol: builds write-single and
  write-multiple frames in ASCII or RTU framing, streams them as bytes to a
  character transmitter, and checks the slave's reply.
  Assumes a character UART outside on tx/rx byte ports, synchronous to clk_sys.
*/
`timescale 1ns/10ps
module frame_master
  import serial_frame_pkg::*;
#(
  parameter int SILENT_CYCLES = SILENT_CYC,
  parameter int RESP_CYCLES   = RESP_TIMEOUT_CYC,
  parameter int FIFO_DEPTH    = FIFO_WORDS
) (
  input  wire logic              clk_sys,     // 40 MHz clock
  input  wire logic              rst,         // Synchronous reset
  input  wire logic              cmd_valid,   // Command request
  output logic                   cmd_ready,   // Sequencer idle
  input  wire logic              cmd_ascii,   // 1 ASCII, 0 RTU
  input  wire logic              cmd_multi,   // 1 write multiple, 0 write single
  input  wire logic [7:0]        cmd_station, // Slave station address
  input  wire logic [15:0]       cmd_addr,    // Start data address
  input  wire logic [3:0]        cmd_words,   // Word count, multi only
  input  wire logic              wr_valid,    // Data word offered
  output logic                   wr_ready,    // FIFO has room
  input  wire logic [WORD_W-1:0] wr_data,     // Data word
  output logic                   tx_valid,    // Byte to transmitter
  input  wire logic              tx_ready,    // Transmitter takes byte
  output logic      [7:0]        tx_byte,     // Byte to send
  input  wire logic              rx_valid,    // Received byte strobe
  input  wire logic [7:0]        rx_byte,     // Received byte
  output logic                   done,        // Command finished pulse
  output logic      [2:0]        status       // Result code
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  seq_state_t        state;
  logic              ascii;
  logic              multi;
  logic [7:0]        station;
  logic [15:0]       addr;
  logic [3:0]        words;
  logic [4:0]        idx;
  logic              sub;
  logic [CNT_W-1:0]  gap_cnt;
  logic [7:0]        lrc;
  logic [15:0]       crc;
  logic [WORD_W-1:0] first_word;
  logic              f_valid;
  logic              f_ready;
  logic [WORD_W-1:0] f_data;
  logic              emit;
  logic              load;
  logic [7:0]        load_byte;
  logic              bin_done;
  logic [7:0]        cur;
  logic [7:0]        lrc_out;
  logic [4:0]        frame_len;
  logic              is_data;
  logic              is_lo;
  logic              data_ok;
  logic              gap_done;
  logic              accept;
  logic              words_ok;
  logic              rx_started;
  logic              rx_sub;
  logic              rx_cr;
  logic [3:0]        rx_hi;
  logic [3:0]        rx_cnt;
  logic              rx_bad;
  logic [7:0]        rx_lrc;
  logic [15:0]       rx_crc;
  logic [CNT_W-1:0]  rx_idle;
  logic [4:0]        rx_hex;
  logic              rx_bin_v;
  logic [7:0]        rx_bin;
  logic              asc_end;
  logic              rtu_end;
  logic              timeout;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] c_in, input logic [7:0] b);
    logic [15:0] c;
    c = c_in ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  // Returns {valid, nibble}; lower case accepted as well
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, 4'(c - 8'h30)};
    if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c - 8'h37)};
    if (c >= 8'h61 && c <= 8'h66) return {1'b1, 4'(c - 8'h57)};
    return 5'h00;
  endfunction

  // Binary byte i of the command; the reply echoes bytes 0..5
  function automatic logic [7:0] frame_byte(input logic [4:0] i, input logic [15:0] w);
    case (i)
      5'd0:    return station;
      5'd1:    return multi ? FUNC_WR_MULTI : FUNC_WR_SINGLE;
      5'd2:    return addr[15:8];
      5'd3:    return addr[7:0];
      5'd4:    return multi ? 8'h00 : w[15:8];
      5'd5:    return multi ? {4'h0, words} : w[7:0];
      5'd6:    return {3'h0, words, 1'b0};
      default: return i[0] ? w[15:8] : w[7:0];
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Data word buffer
  // ----------------------------------------------------------------------
  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // ----------------------------------------------------------------------
  // Transmit byte selection
  // ----------------------------------------------------------------------
  assign cmd_ready = (state == S_IDLE);
  assign accept    = (state == S_IDLE) && cmd_valid;
  assign words_ok  = !cmd_multi || (cmd_words != 4'h0 && cmd_words <= MAX_WORDS);
  assign emit      = !tx_valid || tx_ready;
  assign frame_len = multi ? (5'd7 + {words, 1'b0}) : 5'd6;
  assign is_data   = multi ? (idx >= 5'd7) : (idx >= 5'd4);
  assign is_lo     = is_data && (multi ? !idx[0] : idx[0]);
  assign data_ok   = !is_data || f_valid;
  // Always_comb also wakes on the latched fields read inside the function
  always_comb begin
    cur = frame_byte(idx, f_data);
  end
  assign lrc_out   = ~lrc + 8'h01;
  assign gap_done  = (gap_cnt == CNT_W'(SILENT_CYCLES - 1));
  // Words leave the FIFO in order, one per low byte
  assign f_ready   = (state == S_BODY) && emit && data_ok && bin_done && is_lo;

  always_comb begin
    load      = 1'b0;
    load_byte = 8'h00;
    bin_done  = 1'b0;
    case (state)
      S_LEAD: begin
        load      = ascii;
        load_byte = CHAR_START;
      end
      S_BODY: begin
        load      = data_ok;
        load_byte = ascii ? hex_char(sub ? cur[3:0] : cur[7:4]) : cur;
        bin_done  = data_ok && (!ascii || sub);
      end
      S_CHECK: begin
        load = 1'b1;
        if (ascii) begin
          load_byte = hex_char(sub ? lrc_out[3:0] : lrc_out[7:4]);
        end else begin
          load_byte = sub ? crc[15:8] : crc[7:0];
        end
      end
      S_TAIL: begin
        load      = ascii;
        load_byte = sub ? CHAR_LF : CHAR_CR;
      end
      default: begin
        load = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_byte  <= 8'h00;
    end else if (emit) begin
      tx_valid <= load;
      tx_byte  <= load_byte;
    end
  end

  // ----------------------------------------------------------------------
  // Command latch
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ascii   <= 1'b0;
      multi   <= 1'b0;
      station <= 8'h00;
      addr    <= 16'h0000;
      words   <= 4'h0;
    end else if (accept) begin
      ascii   <= cmd_ascii;
      multi   <= cmd_multi;
      station <= cmd_station;
      addr    <= cmd_addr;
      words   <= cmd_words;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      first_word <= '0;
    end else if (f_ready && !multi) begin
      first_word <= f_data;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= S_IDLE;
      idx   <= 5'd0;
      sub   <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          idx <= 5'd0;
          sub <= 1'b0;
          if (accept && words_ok) state <= S_LEAD;
        end
        S_LEAD: begin
          if (ascii ? emit : gap_done) state <= S_BODY;
        end
        S_BODY: begin
          if (emit && load) begin
            if (ascii) sub <= ~sub;
            if (bin_done) begin
              idx <= idx + 5'd1;
              if (idx == frame_len - 5'd1) begin
                state <= S_CHECK;
                sub   <= 1'b0;
              end
            end
          end
        end
        S_CHECK: begin
          if (emit) begin
            sub <= ~sub;
            if (sub) state <= S_TAIL;
          end
        end
        S_TAIL: begin
          if (ascii ? (emit && sub) : gap_done) state <= S_WAIT;
          if (ascii && emit) sub <= ~sub;
        end
        S_WAIT: begin
          if (asc_end || rtu_end || timeout) state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Trailing gap counts from the last byte handed over; UART shift time only adds silence
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gap_cnt <= '0;
    end else if (!ascii && (state == S_LEAD || (state == S_TAIL && !tx_valid))) begin
      gap_cnt <= gap_done ? '0 : gap_cnt + 1'b1;
    end else begin
      gap_cnt <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit check accumulation
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || accept) begin
      lrc <= LRC_INIT;
      crc <= CRC_INIT;
    end else if (state == S_BODY && emit && bin_done) begin
      lrc <= lrc + cur;
      crc <= crc_byte(crc, cur);
    end
  end

  // ----------------------------------------------------------------------
  // Reply receiver
  // ----------------------------------------------------------------------
  assign rx_hex   = hex_val(rx_byte);
  assign rx_bin_v = ascii ? (rx_valid && rx_started && !rx_cr && rx_hex[4] && rx_sub)
                          : rx_valid;
  assign rx_bin   = ascii ? {rx_hi, rx_hex[3:0]} : rx_byte;
  assign asc_end  = (state == S_WAIT) && ascii && rx_valid && rx_started && rx_cr
                    && rx_byte == CHAR_LF;
  assign rtu_end  = (state == S_WAIT) && !ascii && rx_started && !rx_valid
                    && rx_idle == CNT_W'(SILENT_CYCLES - 1);
  // A dropped command shows only as silence
  assign timeout  = (state == S_WAIT) && !rx_valid && !rtu_end
                    && rx_idle == CNT_W'(RESP_CYCLES - 1);

  always_ff @(posedge clk_sys) begin
    if (rst || state != S_WAIT) begin
      rx_started <= 1'b0;
      rx_sub     <= 1'b0;
      rx_cr      <= 1'b0;
      rx_hi      <= 4'h0;
      rx_idle    <= '0;
    end else begin
      rx_idle <= rx_valid ? '0 : rx_idle + 1'b1;
      if (rx_valid) begin
        if (!ascii) begin
          rx_started <= 1'b1;
        end else if (rx_byte == CHAR_START) begin
          rx_started <= 1'b1;
          rx_sub     <= 1'b0;
          rx_cr      <= 1'b0;
        end else if (rx_started && !rx_cr) begin
          if (rx_byte == CHAR_CR) begin
            rx_cr <= 1'b1;
          end else if (rx_hex[4]) begin
            rx_sub <= ~rx_sub;
            rx_hi  <= rx_hex[3:0];
          end
        end
      end
    end
  end

  // A fresh colon restarts the reply, dropping earlier noise
  always_ff @(posedge clk_sys) begin
    if (rst || state != S_WAIT || (ascii && rx_valid && rx_byte == CHAR_START)) begin
      rx_cnt <= 4'h0;
      rx_bad <= 1'b0;
      rx_lrc <= LRC_INIT;
      rx_crc <= CRC_INIT;
    end else begin
      if (ascii && rx_valid && rx_started) begin
        if (rx_cr ? (rx_byte != CHAR_LF) : (rx_byte == CHAR_CR ? rx_sub : !rx_hex[4])) begin
          rx_bad <= 1'b1;
        end
      end
      if (rx_bin_v) begin
        if (rx_cnt != 4'hf) rx_cnt <= rx_cnt + 4'h1;
        if (rx_cnt < REPLY_ECHO_LEN && rx_bin != frame_byte({1'b0, rx_cnt}, first_word)) begin
          rx_bad <= 1'b1;
        end
        rx_lrc <= rx_lrc + rx_bin;
        rx_crc <= crc_byte(rx_crc, rx_bin);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Result
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done   <= 1'b0;
      status <= ST_OK;
    end else begin
      done <= 1'b0;
      if (accept && !words_ok) begin
        done   <= 1'b1;
        status <= ST_REFUSED;
      end else if (timeout) begin
        done   <= 1'b1;
        status <= ST_TIMEOUT;
      end else if (asc_end || rtu_end) begin
        done <= 1'b1;
        // Same framing and check style expected back
        if (rx_bad || rx_cnt != (ascii ? REPLY_LEN_ASC : REPLY_LEN_RTU)) begin
          status <= ST_MISMATCH;
        end else if (ascii ? (rx_lrc != 8'h00) : (rx_crc != 16'h0000)) begin
          status <= ST_CHECK;
        end else begin
          status <= ST_OK;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_check_seed: assert property (@(posedge clk_sys) disable iff (rst)
    accept |=> crc == CRC_INIT && lrc == LRC_INIT)
    else $error("check registers not seeded at command start");
  a_lead_gap: assert property (@(posedge clk_sys) disable iff (rst)
    ($rose(state == S_BODY) && !ascii) |-> $past(gap_cnt) == CNT_W'(SILENT_CYCLES - 1))
    else $error("RTU frame started before the silent gap");
  a_tail_gap: assert property (@(posedge clk_sys) disable iff (rst)
    ($rose(state == S_WAIT) && !ascii) |-> $past(gap_cnt) == CNT_W'(SILENT_CYCLES - 1))
    else $error("RTU frame end without the silent gap");
  a_colon_first: assert property (@(posedge clk_sys) disable iff (rst)
    (state == S_LEAD && ascii && emit) |=> tx_valid && tx_byte == CHAR_START && state == S_BODY)
    else $error("ASCII frame does not open with a colon");
  a_cr_then_lf: assert property (@(posedge clk_sys) disable iff (rst)
    (state == S_TAIL && ascii && !sub && emit) |=> tx_byte == CHAR_CR && sub && state == S_TAIL)
    else $error("ASCII frame end is not CR before LF");
  a_crc_low_first: assert property (@(posedge clk_sys) disable iff (rst)
    (state == S_CHECK && !ascii && !sub && emit)
      |=> ({8'h00, tx_byte} == ($past(crc) & 16'h00ff)) && sub)
    else $error("CRC low byte not sent first");
  a_lrc_sent: assert property (@(posedge clk_sys) disable iff (rst)
    (state == S_CHECK && ascii && !sub && emit) |=> tx_byte == hex_char(lrc_out[7:4])
      && lrc_out + $past(lrc) == 8'h00)
    else $error("LRC character wrong");
  a_byte_count: assert property (@(posedge clk_sys) disable iff (rst)
    (state == S_BODY && multi && !ascii && idx == 5'd6 && emit) |=> tx_byte == {3'h0, words, 1'b0})
    else $error("byte count field wrong");
  a_word_limit: assert property (@(posedge clk_sys) disable iff (rst)
    (state != S_IDLE && multi) |-> words != 4'h0 && words <= MAX_WORDS)
    else $error("word count out of range in flight");
  a_pop_on_low: assert property (@(posedge clk_sys) disable iff (rst)
    f_ready |-> state == S_BODY && is_lo && f_valid)
    else $error("data word consumed off its low byte");
  a_reply_len: assert property (@(posedge clk_sys) disable iff (rst)
    (done && status == ST_OK) |-> rx_cnt == (ascii ? REPLY_LEN_ASC : REPLY_LEN_RTU))
    else $error("good reply of wrong length");

endmodule // frame_master

// ===== tb/slave_model.sv
/* Byte-level slave model and check sums. Assumes frame_master byte ports. */
`timescale 1ns/10ps
package chk_pkg;
  typedef logic [7:0] bq_t[$];
  function automatic logic [15:0] crc16(bq_t b);
    logic [15:0] c = 16'hffff;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  function automatic logic [7:0] lrc(bq_t b);
    logic [7:0] s = 8'h00;
    foreach (b[i]) s += b[i];
    return -s;
  endfunction
  function automatic logic [7:0] hx(logic [3:0] n);
    return n < 10 ? 8'h30 + n : 8'h37 + n;
  endfunction
  function automatic logic [3:0] nib(logic [7:0] c);
    return c > 8'h39 ? 4'(c - 8'h37) : 4'(c - 8'h30);
  endfunction
  function automatic bq_t wrap(logic a, bq_t b);
    logic [15:0] c = crc16(b);
    logic [7:0] l = lrc(b);
    bq_t f = {8'h3a};
    if (!a) return {b, c[7:0], c[15:8]};
    foreach (b[i]) f = {f, hx(b[i][7:4]), hx(b[i][3:0])};
    return {f, hx(l[7:4]), hx(l[3:0]), 8'h0d, 8'h0a};
  endfunction
endpackage
module slave_model
  import chk_pkg::*;
#(parameter int GAP = 30) (
  input  wire logic       clk_sys,  // Clock
  input  wire logic       tx_valid, // Byte offered
  input  wire logic [7:0] tx_byte,  // Offered byte
  input  wire logic       corrupt,  // Spoil reply CRC (RTU) or station (ASCII)
  output logic            tx_ready, // Byte taken
  output logic            rx_valid, // Reply strobe
  output logic      [7:0] rx_byte   // Reply byte
);
  bq_t q;
  logic [15:0] mem [int];
  int idle = 0;
  int seed = 32'h1f3a57c9;
  initial {tx_ready, rx_valid, rx_byte} = '0;
  task automatic serve();
    logic a = q[0] == 8'h3a;
    int n, o;
    bq_t b, r;
    if (a) for (int i = 1; i + 3 < q.size(); i += 2) b.push_back({nib(q[i]), nib(q[i + 1])});
    else b = q;
    q.delete();
    if (b.size() < 7 || b[0] != 8'h01 || (a ? lrc(b) : crc16(b)) != 0) return;
    n = b[1] == 8'h10 ? b[5] : 1;
    o = b[1] == 8'h10 ? 7 : 4;
    for (int k = 0; k < n; k++) mem[{b[2], b[3]} + k] = {b[o + 2*k], b[o + 2*k + 1]};
    r = wrap(a, b[0:5]);
    if (corrupt) r[a ? 1 : r.size() - 1] = r[a ? 1 : r.size() - 1] ^ 8'h01; // Station or CRC
    repeat (2) @(posedge clk_sys);
    foreach (r[i]) begin
      rx_valid <= 1'b1;
      rx_byte <= r[i];
      @(posedge clk_sys);
    end
    rx_valid <= 1'b0;
  endtask
  always @(posedge clk_sys) begin
    rx_valid <= 1'b0;
    rx_byte <= ~rx_byte; // Released line never holds the last value
    tx_ready <= ($random(seed) & 3) != 0;
    idle = (tx_valid && tx_ready) ? 0 : idle + 1;
    if (tx_valid && tx_ready) q.push_back(tx_byte);
    if (q.size() > 0 && (q[0] == 8'h3a ? q[$] == 8'h0a : idle == GAP)) serve();
  end
endmodule // slave_model

// ===== tb/tb.sv
/* Self-checking bench for frame_master. Assumes slave_model on the byte side. */
`timescale 1ns/10ps
module tb;
  import serial_frame_pkg::*;
  import chk_pkg::*;
  logic clk_sys = 0, rst = 1, cmd_valid = 0, cmd_ascii = 0, cmd_multi = 0, wr_valid = 0;
  logic corrupt = 0, cmd_ready, wr_ready, tx_valid, tx_ready, rx_valid, done;
  logic [7:0] cmd_station = 0, tx_byte, rx_byte;
  logic [15:0] cmd_addr = 0, wr_data = 0;
  logic [3:0] cmd_words = 0;
  logic [2:0] status;
  int n_mismatch = 0, tests_run = 0, seed = 32'h75cc9bef;
  logic [15:0] ref_q[$];
  bq_t got;
  frame_master #(.SILENT_CYCLES(20), .RESP_CYCLES(200)) frame_master_inst (.clk_sys, .rst,
    .cmd_valid, .cmd_ready, .cmd_ascii, .cmd_multi, .cmd_station, .cmd_addr, .cmd_words,
    .wr_valid, .wr_ready, .wr_data, .tx_valid, .tx_ready, .tx_byte, .rx_valid, .rx_byte,
    .done, .status);
  slave_model slave_model_inst (.clk_sys, .tx_valid, .tx_byte, .corrupt, .tx_ready,
    .rx_valid, .rx_byte);
  initial forever #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (tx_valid && tx_ready) got.push_back(tx_byte);
  task automatic check(logic [15:0] seen, logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic fill(int n);
    repeat (n) begin
      @(posedge clk_sys);
      #2 wr_valid = (wr_ready === 1'b1);
      wr_data = 16'($random(seed));
      if (wr_ready === 1'b1) ref_q.push_back(wr_data);
    end
    @(posedge clk_sys);
    #2 wr_valid = 0;
  endtask
  task automatic run(logic a, logic m, logic [7:0] st, int n, logic bad, logic [2:0] es);
    bq_t f;
    logic [15:0] ad = 16'($random(seed));
    int k = 0;
    got.delete();
    f = {st, m ? FUNC_WR_MULTI : FUNC_WR_SINGLE, ad[15:8], ad[7:0]};
    if (m) f = {f, 8'h00, 8'(n), 8'(2 * n)};
    for (int i = 0; i < (m ? n : 1) && es != ST_REFUSED; i++) f = {f, ref_q[i][15:8], ref_q[i][7:0]};
    @(posedge clk_sys);
    #2 {cmd_valid, cmd_ascii, cmd_multi, cmd_station, cmd_addr} = {1'b1, a, m, st, ad};
    {cmd_words, corrupt} = {4'(n), bad};
    @(posedge clk_sys);
    #2 cmd_valid = 0;
    check(16'(cmd_ready), 16'(es == ST_REFUSED));
    while (done !== 1'b1 && k++ < 3000) @(posedge clk_sys) #1;
    check(16'(done), 16'd1);
    check(16'(status), 16'(es));
    if (es == ST_REFUSED) f.delete();
    else f = wrap(a, f);
    check(16'(got.size()), 16'(f.size()));
    foreach (f[i]) check(16'(got[i]), 16'(f[i]));
    for (int i = 0; es != ST_REFUSED && i < (m ? n : 1); i++) begin
      if (es == ST_OK) check(slave_model_inst.mem[ad + i], ref_q[0]);
      void'(ref_q.pop_front());
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    #2 rst = 0;
    run(0, 1, 8'h01, 0, 0, ST_REFUSED);
    run(1, 1, 8'h01, 11, 0, ST_REFUSED);
    fill(40);
    check(16'(ref_q.size()), 16'd33);
    check(16'(wr_ready), 16'd0);
    run(0, 1, 8'h01, 10, 0, ST_OK);
    run(1, 1, 8'h01, 10, 0, ST_OK);
    run(1, 0, 8'h01, 1, 0, ST_OK);
    run(0, 0, 8'h02, 1, 0, ST_TIMEOUT);
    run(0, 1, 8'h01, 10, 1, ST_CHECK);
    run(1, 1, 8'h01, 1, 0, ST_OK);
    fill(1);
    run(1, 0, 8'h01, 1, 1, ST_MISMATCH);
    report_and_stop();
  end
  initial begin
    #500000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // tb
